/* hdl/cdm_consts.vh */
`ifndef CDM_CONSTS_VH
`define CDM_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CDM_OFS_ERR_EN        8'h00
`define CDM_OFS_ERR           8'h04
`define CDM_OFS_STATUS        8'h08
`define CDM_OFS_CLK_COUNT     8'h0C
`define CDM_OFS_IRQ_MASK      8'h10

// ----------------------------------------------------------------
// error / enable / mask bit positions
// ----------------------------------------------------------------
`define CDM_NUM_ERR           5
`define CDM_BIT_REF_MISSING   0
`define CDM_BIT_CONV_ERR      1
`define CDM_BIT_POS_RANGE     2
`define CDM_BIT_NEG_RANGE     3
`define CDM_BIT_REF_RANGE     4
`define CDM_BIT_CLK_CNT_EN    5
`define CDM_EN_WIDTH          6
`define CDM_BIT_SUMMARY       0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDM_RST_ERR_EN        6'h00
`define CDM_RST_ERR           5'h00
`define CDM_RST_IRQ_MASK      5'h00

// ----------------------------------------------------------------
// counts and widths
// ----------------------------------------------------------------
`define CDM_CLK_DIV           131
`define CDM_PRESC_W           8
`define CDM_CLK_COUNT_W       8
`define CDM_SAT_RUN           20
`define CDM_RUN_W             5
`define CDM_DATA_W            24
`define CDM_OFS_COEF_LO       24'h07FFFF
`define CDM_OFS_COEF_HI       24'hF7FFFF

`endif

/* hdl/cdm_clock_counter.v */
`timescale 1ns/1ps
`include "cdm_consts.vh"

module cdm_clock_counter (
    input  wire                          mclk,
    input  wire                          sys_rst,
    input  wire                          ce,
    input  wire                          count_enable,
    output wire [`CDM_CLK_COUNT_W-1:0]   count_value
);

    reg [`CDM_PRESC_W-1:0]     presc_reg;
    reg [`CDM_CLK_COUNT_W-1:0] count_reg;

    // ------------------------------------------------------------
    // divide by 131, then step the count
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            presc_reg <= 8'h00;
            count_reg <= 8'h00;
        end else if (ce) begin
            if (!count_enable) begin
                presc_reg <= 8'h00;
            end else if ({24'h000000, presc_reg} == (`CDM_CLK_DIV - 1)) begin  // [RL14]
                presc_reg <= 8'h00;
                count_reg <= count_reg + 8'h01;                  // [RL15]
            end else begin
                presc_reg <= presc_reg + 8'h01;
            end
        end
    end

    assign count_value = count_reg;

endmodule

/* hdl/cdm_conv_check.v */
`timescale 1ns/1ps
`include "cdm_consts.vh"

module cdm_conv_check (
    input  wire                      mclk,
    input  wire                      sys_rst,
    input  wire                      ce,
    input  wire                      check_enable,
    input  wire                      conv_active,
    input  wire                      filter_over,
    input  wire                      filter_under,
    input  wire                      mod_bit,
    input  wire                      mod_bit_valid,
    input  wire                      data_update,
    input  wire                      offset_cal_done,
    input  wire [`CDM_DATA_W-1:0]    offset_coef,
    input  wire                      gain_cal_active,
    input  wire                      gain_cal_done,
    output wire                      conv_fault,
    output wire                      offset_accept,
    output wire                      gain_accept
);

    reg                  last_bit_reg;
    reg [`CDM_RUN_W-1:0] run_reg;
    reg                  pend_reg;
    reg                  gain_ovf_reg;
    wire                 sat_now;
    wire                 ofs_bad;
    wire                 gain_bad;

    // ------------------------------------------------------------
    // modulator run of identical bits
    // ------------------------------------------------------------
    assign sat_now = mod_bit_valid && (mod_bit == last_bit_reg) &&
                     ({27'h0000000, run_reg} == (`CDM_SAT_RUN - 1));  // [RL6]

    always @(posedge mclk) begin
        if (sys_rst) begin
            last_bit_reg <= 1'b0;
            run_reg      <= 5'h00;
        end else if (ce && mod_bit_valid) begin
            last_bit_reg <= mod_bit;
            if (mod_bit != last_bit_reg || run_reg == 5'h00)
                run_reg <= 5'h01;
            else if ({27'h0000000, run_reg} != `CDM_SAT_RUN)
                run_reg <= run_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // calibration range checks
    // ------------------------------------------------------------
    assign ofs_bad  = (offset_coef < `CDM_OFS_COEF_LO) ||
                      (offset_coef > `CDM_OFS_COEF_HI);          // [RL7]
    assign gain_bad = gain_ovf_reg || (gain_cal_active && filter_over);

    always @(posedge mclk) begin
        if (sys_rst) begin
            gain_ovf_reg <= 1'b0;
        end else if (ce) begin
            if (gain_cal_done)
                gain_ovf_reg <= 1'b0;
            else if (gain_cal_active && filter_over)
                gain_ovf_reg <= 1'b1;                            // [RL8]
        end
    end

    // ------------------------------------------------------------
    // pending fault, reported on data update
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            pend_reg <= 1'b0;
        end else if (ce) begin
            if (data_update)
                pend_reg <= 1'b0;
            else if (check_enable && conv_active &&
                     (filter_over || filter_under || sat_now))   // [RL4]
                pend_reg <= 1'b1;
        end
    end

    assign conv_fault = check_enable &&
        ((data_update && (pend_reg || filter_over || filter_under ||
                          (conv_active && sat_now))) ||      // [RL9] [RL5]
         (offset_cal_done && ofs_bad) ||
         (gain_cal_done && gain_bad));
    assign offset_accept = offset_cal_done && !ofs_bad;          // [RL7]
    assign gain_accept   = gain_cal_done && !gain_bad;           // [RL8]

endmodule

/* hdl/cdm_top.v */
// Behaviour
// [RL1] with reference check on, low or open reference sets reference-missing flag
// [RL2] a set reference-missing flag also raises the summary error flag
// [RL3] host reads errors after standby exit and clears reference-missing
// [RL4] with converter check on, faults in conversion or calibration set converter flag
// [RL5] filter overflow/underflow sets converter flag and clamps result to ones/zeros
// [RL6] twenty identical modulator bits in a row set the converter flag
// [RL7] offset coefficient outside limits keeps old offset and sets converter flag
// [RL8] filter overflow in gain calibration keeps old gain and sets converter flag
// [RL9] converter flag updates with data update, clears only by writing one
// [RL10] separate enables and flags for positive and negative input range
// [RL11] enabled input monitor flags pin above positive or below negative supply
// [RL12] enabled reference monitor flags reference over or under supply
// [RL13] input and reference range flags are sticky, cleared by writing one
// [RL14] enabled clock counter steps once every 131 master clocks
// [RL15] clock counter wraps to zero after its maximum and keeps counting
// [RL16] summary flag follows any enabled error flag still set
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "cdm_consts.vh"

module cdm_top (
    input  wire                      mclk,
    input  wire                      sys_rst,
    input  wire                      ce,
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [7:0]                paddr,
    input  wire [31:0]               pwdata,
    output reg  [31:0]               prdata,
    output reg                       pready,
    output reg                       pslverr,
    input  wire                      ref_below_threshold,
    input  wire                      ref_open,
    input  wire                      conv_active,
    input  wire                      filter_over,
    input  wire                      filter_under,
    input  wire                      mod_bit,
    input  wire                      mod_bit_valid,
    input  wire                      data_update,
    input  wire [`CDM_DATA_W-1:0]    raw_result,
    input  wire                      offset_cal_done,
    input  wire [`CDM_DATA_W-1:0]    offset_coef,
    input  wire                      gain_cal_active,
    input  wire                      gain_cal_done,
    input  wire                      pos_input_over,
    input  wire                      pos_input_under,
    input  wire                      neg_input_over,
    input  wire                      neg_input_under,
    input  wire                      refp_over,
    input  wire                      refn_under,
    output reg  [`CDM_DATA_W-1:0]    result,
    output reg                       result_valid,
    output reg                       offset_update,
    output reg                       gain_update,
    output reg                       summary_error,
    output reg                       irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg  [`CDM_EN_WIDTH-1:0]        err_en_reg;
    reg  [`CDM_NUM_ERR-1:0]         err_reg;
    reg  [`CDM_NUM_ERR-1:0]         err_next;
    reg  [`CDM_NUM_ERR-1:0]         mask_reg;
    reg  [`CDM_NUM_ERR-1:0]         set_vec;
    reg  [`CDM_NUM_ERR-1:0]         clr_vec;
    reg  [31:0]                     rd_data;
    reg                             rd_ok;
    wire [`CDM_CLK_COUNT_W-1:0]     clk_count;
    wire                            conv_fault;
    wire                            offset_accept;
    wire                            gain_accept;
    wire                            acc_phase;
    wire                            wr_commit;
    wire [`CDM_NUM_ERR-1:0]         err_active;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `CDM_OFS_ERR_EN)    || (addr == `CDM_OFS_ERR) ||
                     (addr == `CDM_OFS_STATUS)    || (addr == `CDM_OFS_CLK_COUNT) ||
                     (addr == `CDM_OFS_IRQ_MASK);
        end
    endfunction

    assign acc_phase = psel && penable;
    assign wr_commit = acc_phase && pready && pwrite && mapped(paddr);

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    cdm_clock_counter u_clk_cnt (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .ce           (ce),
        .count_enable (err_en_reg[`CDM_BIT_CLK_CNT_EN]),
        .count_value  (clk_count)
    );

    cdm_conv_check u_conv_chk (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .ce              (ce),
        .check_enable    (err_en_reg[`CDM_BIT_CONV_ERR]),
        .conv_active     (conv_active),
        .filter_over     (filter_over),
        .filter_under    (filter_under),
        .mod_bit         (mod_bit),
        .mod_bit_valid   (mod_bit_valid),
        .data_update     (data_update),
        .offset_cal_done (offset_cal_done),
        .offset_coef     (offset_coef),
        .gain_cal_active (gain_cal_active),
        .gain_cal_done   (gain_cal_done),
        .conv_fault      (conv_fault),
        .offset_accept   (offset_accept),
        .gain_accept     (gain_accept)
    );

    // ------------------------------------------------------------
    // error events
    // ------------------------------------------------------------
    always @* begin
        set_vec = 5'h00;
        set_vec[`CDM_BIT_REF_MISSING] = err_en_reg[`CDM_BIT_REF_MISSING] &&
                                        (ref_below_threshold || ref_open);   // [RL1]
        set_vec[`CDM_BIT_CONV_ERR]    = conv_fault;                          // [RL4]
        set_vec[`CDM_BIT_POS_RANGE]   = err_en_reg[`CDM_BIT_POS_RANGE] &&
                                        (pos_input_over || pos_input_under); // [RL10] [RL11]
        set_vec[`CDM_BIT_NEG_RANGE]   = err_en_reg[`CDM_BIT_NEG_RANGE] &&
                                        (neg_input_over || neg_input_under); // [RL10] [RL11]
        set_vec[`CDM_BIT_REF_RANGE]   = err_en_reg[`CDM_BIT_REF_RANGE] &&
                                        (refp_over || refn_under);           // [RL12]
    end

    // ------------------------------------------------------------
    // sticky flags, write one to clear, set wins
    // ------------------------------------------------------------
    always @* begin
        clr_vec = 5'h00;
        if (wr_commit && paddr == `CDM_OFS_ERR)
            clr_vec = pwdata[`CDM_NUM_ERR-1:0];
        err_next = (err_reg & ~clr_vec) | set_vec;                           // [RL9] [RL13]
    end

    assign err_active = err_next & err_en_reg[`CDM_NUM_ERR-1:0];

    // ------------------------------------------------------------
    // register writes and flags
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            err_en_reg    <= `CDM_RST_ERR_EN;
            err_reg       <= `CDM_RST_ERR;
            mask_reg      <= `CDM_RST_IRQ_MASK;
            summary_error <= 1'b0;
            irq           <= 1'b0;
        end else if (ce) begin
            err_reg <= err_next;
            if (wr_commit && paddr == `CDM_OFS_ERR_EN)
                err_en_reg <= pwdata[`CDM_EN_WIDTH-1:0];
            if (wr_commit && paddr == `CDM_OFS_IRQ_MASK)
                mask_reg <= pwdata[`CDM_NUM_ERR-1:0];
            summary_error <= (|err_active) ||
                             err_next[`CDM_BIT_REF_MISSING];                 // [RL2] [RL16]
            irq <= |(err_next & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // result clamp and calibration updates
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            result        <= 24'h000000;
            result_valid  <= 1'b0;
            offset_update <= 1'b0;
            gain_update   <= 1'b0;
        end else if (ce) begin
            result_valid  <= data_update;
            offset_update <= offset_accept;                                  // [RL7]
            gain_update   <= gain_accept;                                    // [RL8]
            if (data_update) begin
                if (filter_over)
                    result <= 24'hFFFFFF;                                    // [RL5]
                else if (filter_under)
                    result <= 24'h000000;                                    // [RL5]
                else
                    result <= raw_result;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always @* begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        case (paddr)
            `CDM_OFS_ERR_EN:    rd_data[`CDM_EN_WIDTH-1:0]     = err_en_reg;
            `CDM_OFS_ERR:       rd_data[`CDM_NUM_ERR-1:0]      = err_reg;
            `CDM_OFS_STATUS:    rd_data[`CDM_BIT_SUMMARY]      = summary_error;
            `CDM_OFS_CLK_COUNT: rd_data[`CDM_CLK_COUNT_W-1:0]  = clk_count;
            `CDM_OFS_IRQ_MASK:  rd_data[`CDM_NUM_ERR-1:0]      = mask_reg;
            default:            rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // apb answer, one wait state
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            if (acc_phase && !pready) begin
                pready  <= 1'b1;
                pslverr <= !rd_ok;
                prdata  <= pwrite ? 32'h00000000 : rd_data;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

/* testbench/cdm_top_chk.sv */
`timescale 1ns/1ps
`include "cdm_consts.vh"

module cdm_top_chk (
    input wire                   mclk,
    input wire                   sys_rst,
    input wire                   ce,
    input wire                   psel,
    input wire                   penable,
    input wire                   pwrite,
    input wire                   pready,
    input wire                   pslverr,
    input wire                   data_update,
    input wire                   filter_over,
    input wire                   filter_under,
    input wire [`CDM_DATA_W-1:0] raw_result,
    input wire [`CDM_DATA_W-1:0] result,
    input wire                   result_valid,
    input wire                   offset_cal_done,
    input wire [`CDM_DATA_W-1:0] offset_coef,
    input wire                   offset_update,
    input wire                   gain_cal_done,
    input wire                   gain_update,
    input wire                   summary_error,
    input wire                   irq
);
    // ------------------------------
    // bus, result and flag checks
    // ------------------------------
    wire apw = psel && penable && pready && pwrite;
    wire bad = (offset_coef < `CDM_OFS_COEF_LO) || (offset_coef > `CDM_OFS_COEF_HI);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_APB_WAIT: assert property (ce && psel && penable && !pready |=> pready)
        else $error("apb answer missing");
    AST_APB_PULSE: assert property (ce && pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_CLAMP_HI: assert property (ce && data_update && filter_over |=> result == 24'hFFFFFF)
        else $error("overflow result not clamped high");
    AST_CLAMP_LO: assert property (ce && data_update && filter_under && !filter_over
        |=> result == 24'h000000) else $error("underflow result not clamped low");
    AST_PASS: assert property (ce && data_update && !filter_over && !filter_under
        |=> result_valid && result == $past(raw_result)) else $error("result not passed");
    AST_OFS_REJ: assert property (ce && offset_cal_done && bad |=> !offset_update)
        else $error("offset out of range accepted");
    AST_OFS_ACC: assert property (ce && offset_cal_done && !bad |=> offset_update)
        else $error("offset in range refused");
    AST_GAIN_SRC: assert property (gain_update |-> $past(gain_cal_done))
        else $error("gain update without calibration end");
    AST_SUM_HOLD: assert property ($fell(summary_error) |-> $past(apw) || $past(apw, 2))
        else $error("summary dropped without write");
    AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(apw) || $past(apw, 2))
        else $error("irq dropped without write");

    cover property (data_update && filter_over);
    cover property (offset_cal_done && bad);
    cover property ($rose(irq));
    cover property ($fell(summary_error));
endmodule

bind cdm_top cdm_top_chk i_chk (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .data_update(data_update),
    .filter_over(filter_over), .filter_under(filter_under), .raw_result(raw_result),
    .result(result), .result_valid(result_valid), .offset_cal_done(offset_cal_done),
    .offset_coef(offset_coef), .offset_update(offset_update),
    .gain_cal_done(gain_cal_done), .gain_update(gain_update),
    .summary_error(summary_error), .irq(irq)
);

/* testbench/cdm_top_test.sv */
`timescale 1ns/1ps
`include "cdm_consts.vh"

module cdm_top_test;
    // ------------------------------
    // stimulus and model state
    // ------------------------------
    logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        conv_active = 1'b0, filter_over = 1'b0, filter_under = 1'b0, ce = 1'b1;
    logic        mod_bit = 1'b0, mod_bit_valid = 1'b0, data_update = 1'b0;
    logic        offset_cal_done = 1'b0, gain_cal_active = 1'b0, gain_cal_done = 1'b0;
    logic [7:0]  paddr = 8'h00, ev = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [23:0] raw_result = 24'h0, offset_coef = 24'h0, exp_q[$];
    logic [23:0] ofs_v [4] = '{24'h07FFFE, 24'h07FFFF, 24'hF7FFFF, 24'hF80000};
    logic        rerr;
    integer      fail_count = 0, cmp_count = 0, seed = 11, r, k, e, b;
    wire  [31:0] prdata;
    wire  [23:0] result;
    wire         pready, pslverr, result_valid, offset_update, gain_update;
    wire         summary_error, irq;

    always #25 mclk = ~mclk;

    cdm_top i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_below_threshold(ev[0]), .ref_open(ev[1]),
        .conv_active(conv_active), .filter_over(filter_over), .filter_under(filter_under),
        .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid), .data_update(data_update),
        .raw_result(raw_result), .offset_cal_done(offset_cal_done), .offset_coef(offset_coef),
        .gain_cal_active(gain_cal_active), .gain_cal_done(gain_cal_done),
        .pos_input_over(ev[2]), .pos_input_under(ev[3]), .neg_input_over(ev[4]),
        .neg_input_under(ev[5]), .refp_over(ev[6]), .refn_under(ev[7]), .result(result),
        .result_valid(result_valid), .offset_update(offset_update), .gain_update(gain_update),
        .summary_error(summary_error), .irq(irq)
    );

    // ------------------------------
    // tasks
    // ------------------------------
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer t;
        t = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            t = t + 1;
            if (t > 20) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t bus timeout", $time);
                print_verdict;
            end
            @(posedge mclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp, "read");
    endtask

    task automatic cv(input logic fo, input logic fu);
        r = $random(seed);
        exp_q.push_back(fo ? 24'hFFFFFF : (fu ? 24'h000000 : r[23:0]));
        raw_result   <= r[23:0];
        filter_over  <= fo;
        filter_under <= fu;
        data_update  <= 1'b1;
        @(posedge mclk);
        filter_over  <= 1'b0;
        filter_under <= 1'b0;
        data_update  <= 1'b0;
        @(posedge mclk);
        chk(result_valid, 32'h1, "valid");
        chk(result, exp_q.pop_front(), "result");
    endtask

    task automatic mrun(input integer c, input logic v);
        mod_bit       <= v;
        mod_bit_valid <= 1'b1;
        repeat (c) @(posedge mclk);
        mod_bit_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // ------------------------------
    // sequence
    // ------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (k = 0; k < 5; k = k + 1)
            rd(8'(4 * k), 32'h0);
        apb(1'b1, 8'h20, 32'h1F);
        chk(rerr, 32'h1, "unmapped");
        for (e = 0; e < 2; e = e + 1) begin
            apb(1'b1, `CDM_OFS_ERR_EN, e ? 32'h1F : 32'h0);
            for (k = 0; k < 8; k = k + 1) begin
                r = $random(seed) & 31;
                b = (k < 2) ? 0 : k / 2 + 1;
                apb(1'b1, `CDM_OFS_IRQ_MASK, r);
                ev <= 8'h01 << k;
                @(posedge mclk);
                ev <= 8'h00;
                @(posedge mclk);
                chk(summary_error, e, "summary");
                chk(irq, e & (r >> b), "irq");
                rd(`CDM_OFS_ERR, e << b);
                rd(`CDM_OFS_STATUS, e);
                apb(1'b1, `CDM_OFS_ERR, 32'h1F);
                rd(`CDM_OFS_ERR, 32'h0);
                chk(summary_error, 32'h0, "summary");
            end
        end
        apb(1'b1, `CDM_OFS_STATUS, 32'h1);
        rd(`CDM_OFS_STATUS, 32'h0);
        apb(1'b1, `CDM_OFS_ERR_EN, 32'h1D);
        conv_active <= 1'b1;
        cv(1'b1, 1'b0);
        rd(`CDM_OFS_ERR, 32'h0);
        apb(1'b1, `CDM_OFS_ERR_EN, 32'h1F);
        cv(1'b1, 1'b0);
        rd(`CDM_OFS_ERR, 32'h2);
        apb(1'b1, `CDM_OFS_ERR, 32'h2);
        cv(1'b0, 1'b1);
        rd(`CDM_OFS_ERR, 32'h2);
        apb(1'b1, `CDM_OFS_ERR, 32'h2);
        mrun(1, 1'b0);
        mrun(19, 1'b1);
        cv(1'b0, 1'b0);
        rd(`CDM_OFS_ERR, 32'h0);
        mrun(1, 1'b0);
        mrun(20, 1'b1);
        rd(`CDM_OFS_ERR, 32'h0);
        cv(1'b0, 1'b0);
        rd(`CDM_OFS_ERR, 32'h2);
        apb(1'b1, `CDM_OFS_ERR, 32'h2);
        conv_active <= 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            offset_coef     <= ofs_v[k];
            offset_cal_done <= 1'b1;
            @(posedge mclk);
            offset_cal_done <= 1'b0;
            @(posedge mclk);
            chk(offset_update, k == 1 || k == 2, "offset");
            rd(`CDM_OFS_ERR, (k == 0 || k == 3) ? 32'h2 : 32'h0);
            apb(1'b1, `CDM_OFS_ERR, 32'h2);
        end
        for (k = 0; k < 2; k = k + 1) begin
            gain_cal_active <= 1'b1;
            filter_over     <= k == 0;
            @(posedge mclk);
            filter_over   <= 1'b0;
            gain_cal_done <= 1'b1;
            @(posedge mclk);
            gain_cal_active <= 1'b0;
            gain_cal_done   <= 1'b0;
            @(posedge mclk);
            chk(gain_update, k, "gain");
            rd(`CDM_OFS_ERR, k ? 32'h0 : 32'h2);
            apb(1'b1, `CDM_OFS_ERR, 32'h2);
        end
        apb(1'b1, `CDM_OFS_ERR_EN, 32'h20);
        ce <= 1'b0;
        repeat (500) @(posedge mclk);
        ce <= 1'b1;
        repeat (131 * 258 + 60) @(posedge mclk);
        apb(1'b1, `CDM_OFS_ERR_EN, 32'h0);
        rd(`CDM_OFS_CLK_COUNT, 32'h2);
        print_verdict;
    end
endmodule
